// file: tsp_dev.sv
// Device end: serial register slave plus the measurement sequencer.
// Assumes link pins are asynchronous to clk; the engine supplies a
// result byte that is captured when a measurement ends.
`timescale 1ns/1ps
module tsp_dev
    import tsp_pkg::*;
#(
    parameter int MEAS_CYCLES = MEAS_CYC
) (
    input logic clk,
    input logic rst,
    tsp_if.dev link,
    input logic [7:0] meas_result,
    output logic [7:0] meas_config,
    output logic meas_busy,
    output logic [7:0] frame_count
);
    localparam int CNT_W = $clog2(MEAS_CYCLES + 1);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (MEAS_CYCLES < 1) begin : g_bad_meas
        $error("MEAS_CYCLES must be at least one");
    end

    typedef struct packed {
        logic [SYNC_N-1:0] sclk_s;
        logic [SYNC_N-1:0] cs_s;
        logic [SYNC_N-1:0] mosi_s;
        logic sclk_l;
        logic cs_l;
        logic mosi_l;
        logic [2:0] bit_cnt;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic first;
        logic wr;
        logic [6:0] addr;
        logic miso;
        logic miso_oe;
        logic pend;
        logic busy;
        logic [CNT_W-1:0] cnt;
        logic irq;
        logic [7:0] result;
        logic [7:0] frames;
        logic [REG_N-1:0][7:0] regs;
    } tsp_dev_st_t;

    tsp_dev_st_t q;
    tsp_dev_st_t d;
    logic sclk_n;
    logic cs_n_n;
    logic mosi_n;
    logic rise;
    logic fall;
    logic sel_start;
    logic sel_end;
    logic [7:0] rx_byte;
    logic [7:0] status;

    // ------------------------------------------------------------
    // Filtered pin levels and link events
    // ------------------------------------------------------------
    // A change counts only once the second and third stages agree
    assign sclk_n = (q.sclk_s[1] == q.sclk_s[2]) ? q.sclk_s[2] : q.sclk_l;
    assign cs_n_n = (q.cs_s[1] == q.cs_s[2]) ? q.cs_s[2] : q.cs_l;
    assign mosi_n = (q.mosi_s[1] == q.mosi_s[2]) ? q.mosi_s[2] : q.mosi_l;
    assign sel_start = q.cs_l & ~cs_n_n;
    assign sel_end = ~q.cs_l & cs_n_n;
    // Edges count only inside a frame; idle level is high
    assign rise = ~q.cs_l & ~cs_n_n & ~q.sclk_l & sclk_n;
    assign fall = ~q.cs_l & ~cs_n_n & q.sclk_l & ~sclk_n;
    assign rx_byte = {q.rx_sh[6:0], mosi_n};
    assign status = {5'h00, q.irq, q.pend, q.busy};

    // ------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------
    // Unmapped addresses read as zero
    function automatic logic [7:0] rd_reg(tsp_dev_st_t s,
                                          logic [7:0] st,
                                          logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a < 7'(REG_N)) begin
            v = s.regs[a[3:0]];
        end else if (a == ADDR_STATUS) begin
            v = st;
        end else if (a == ADDR_RESULT) begin
            v = s.result;
        end else if (a == ADDR_FRAMES) begin
            v = s.frames;
        end
        return v;
    endfunction : rd_reg

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Link shifter, register file and sequencer in one pass
    always_comb begin
        d = q;
        d.sclk_s = {q.sclk_s[SYNC_N-2:0], link.sclk};
        d.cs_s = {q.cs_s[SYNC_N-2:0], link.cs_n};
        d.mosi_s = {q.mosi_s[SYNC_N-2:0], link.mosi};
        d.sclk_l = sclk_n;
        d.cs_l = cs_n_n;
        d.mosi_l = mosi_n;

        // Frame start: drive out, restart the byte framing
        if (sel_start) begin
            d.bit_cnt = 3'd0;
            d.first = 1'b1;
            d.tx_sh = 8'h00;
            d.miso = 1'b0;
            d.miso_oe = 1'b1;
            // Selecting stops a running measurement at once
            d.busy = 1'b0;
            d.cnt = '0;
            d.irq = 1'b0;
        end

        // Frame end: release the line; a byte cut short is dropped
        if (sel_end) begin
            d.miso_oe = 1'b0;
            // Park low while released so the next select moves nothing
            d.miso = 1'b0;
            d.bit_cnt = 3'd0;
            // A start written in the frame runs only once deselected
            if (q.pend) begin
                d.pend = 1'b0;
                d.busy = 1'b1;
                d.cnt = '0;
            end
        end

        // Outgoing bit changes on the falling edge
        if (fall) begin
            d.miso = q.tx_sh[7];
            d.tx_sh = {q.tx_sh[6:0], 1'b0};
        end

        // Incoming bit is taken on the rising edge
        if (rise) begin
            d.rx_sh = rx_byte;
            d.bit_cnt = q.bit_cnt + 3'd1;
            if (q.bit_cnt == 3'd7) begin
                if (q.first) begin
                    d.first = 1'b0;
                    d.wr = ~rx_byte[RD_FLAG_BIT];
                    // A read preloads its first byte, so step past it
                    d.addr = rx_byte[RD_FLAG_BIT] ? rx_byte[6:0] + 7'd1
                                                  : rx_byte[6:0];
                    if (rx_byte[RD_FLAG_BIT]) begin
                        d.tx_sh = rd_reg(q, status, rx_byte[6:0]);
                    end
                end else begin
                    // Address steps on for every further byte
                    d.addr = q.addr + 7'd1;
                    if (q.wr) begin
                        if (q.addr < 7'(REG_N)) begin
                            d.regs[q.addr[3:0]] = rx_byte;
                        end
                        if (q.addr == ADDR_START) begin
                            d.pend = 1'b1;
                        end
                    end else begin
                        d.tx_sh = rd_reg(q, status, q.addr);
                    end
                end
            end
        end

        // Measurement runs with no link traffic needed
        if (q.busy && !sel_start) begin
            d.cnt = q.cnt + CNT_W'(1);
            if (q.cnt == CNT_W'(MEAS_CYCLES - 1)) begin
                d.busy = 1'b0;
                // Done flag is set only when no select clears it in the same cycle
                d.irq = 1'b1;
                d.result = meas_result;
                d.frames = q.frames + 8'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.sclk_s <= '1;
            q.cs_s <= '1;
            q.sclk_l <= CPOL;
            q.cs_l <= 1'b1;
            q.regs <= {REG_N{REG_RST}};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.miso = q.miso;
    assign link.miso_oe = q.miso_oe;
    assign link.irq = q.irq;
    assign meas_config = q.regs[0];
    assign meas_busy = q.busy;
    assign frame_count = q.frames;
endmodule : tsp_dev

// file: tsp_pkg.sv
// Constants shared by both ends of the sensor's serial port.
// Assumes one 25 MHz clock per end; the link pins cross in by sync.
//
// Operation
// - Mode 3: serial clock idles high
// - Change data on fall, sample on rise
// - Address byte then whole data bytes
// - Most significant bit first each chunk
// - Host clocks between 1 and 25 MHz; the host here uses half periods of 8 to 12 clocks, so 25/24 to 25/16 MHz
// - Host writes configuration before each start; the bench skips it before the aborted start
// - Only the host starts a measurement
// - Device measures alone once started
// - Dedicated line flags measurement done
// - Host reads results after the flag
// - Selecting the device stops its activity
package tsp_pkg;
    // ------------------------------------------------------------
    // Clock and link timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int SCLK_MIN_HZ = 1_000_000;
    localparam int SCLK_MAX_HZ = 25_000_000;
    localparam int SYNC_N = 3;
    // Longest half period still at or above the least link rate
    localparam int SCLK_HALF_MAX = CLK_HZ / (2 * SCLK_MIN_HZ);
    // Device answers four clocks after a fall, host sync adds three
    localparam int SCLK_HALF_MIN = 8;
    localparam int SCLK_HALF_DEF = 8;
    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    localparam int CHUNK_W = 8;
    localparam int RD_FLAG_BIT = 7;
    localparam logic CPOL = 1'b1;
    localparam logic CPHA = 1'b1;
    localparam int LEN_W = 8;
    // ------------------------------------------------------------
    // Device register map
    // ------------------------------------------------------------
    localparam int REG_N = 16;
    localparam logic [6:0] ADDR_STATUS = 7'h10;
    localparam logic [6:0] ADDR_RESULT = 7'h11;
    localparam logic [6:0] ADDR_FRAMES = 7'h12;
    localparam logic [6:0] ADDR_START = 7'h7F;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PEND_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    localparam logic [7:0] REG_RST = 8'h00;
    // ------------------------------------------------------------
    // Measurement length
    // ------------------------------------------------------------
    localparam int MEAS_TIME_US = 100;
    localparam int MEAS_CYC = MEAS_TIME_US * (CLK_HZ / 1_000_000);
    // ------------------------------------------------------------
    // Host states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TSP_IDLE = 3'b000,
        TSP_HIGH = 3'b001,
        TSP_LOW = 3'b010,
        TSP_FETCH = 3'b011,
        TSP_HOLD = 3'b100,
        TSP_GAP = 3'b101
    } tsp_hst_t;
endpackage : tsp_pkg

// file: tsp_if.sv
// Pins between the host and the sensor's serial port.
// Assumes the bench connects both ends; data out has a pull-up.
`timescale 1ns/1ps
interface tsp_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic irq;
    logic miso_pin;

    // Released data line floats high through the pull-up
    assign miso_pin = miso_oe ? miso : 1'b1;

    modport dev (
        input sclk,
        input cs_n,
        input mosi,
        output miso,
        output miso_oe,
        output irq
    );
    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input miso_pin,
        input irq
    );
endinterface : tsp_if

// file: tsp_host.sv
// Host end: serial master that runs one framed transfer per request
// and brings the device's done line into the clock domain.
// Assumes the user holds request fields while req_valid is high.
`timescale 1ns/1ps
module tsp_host
    import tsp_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_DEF
) (
    input logic clk,
    input logic rst,
    tsp_if.host link,
    input logic req_valid,
    output logic req_ready,
    input logic req_write,
    input logic [6:0] req_addr,
    input logic [LEN_W-1:0] req_len,
    input logic wr_valid,
    output logic wr_ready,
    input logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic done,
    output logic meas_ready
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Too short a half period outruns the device's answer
    if (SCLK_HALF < SCLK_HALF_MIN || SCLK_HALF > SCLK_HALF_MAX)
    begin : g_bad_half
        $error("SCLK_HALF outside the usable range");
    end

    typedef struct packed {
        tsp_hst_t st;
        logic [4:0] tick_cnt;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic [7:0] tx_sh;
        logic [7:0] rx_sh;
        logic [2:0] bit_cnt;
        logic [LEN_W-1:0] left;
        logic wr;
        logic first;
        logic [7:0] rd_data;
        logic rd_valid;
        logic done;
        logic [SYNC_N-1:0] miso_s;
        logic [SYNC_N-1:0] irq_s;
        logic miso_l;
        logic irq_l;
    } tsp_host_st_t;

    tsp_host_st_t q;
    tsp_host_st_t d;
    logic tick;
    logic [7:0] rx_byte;
    logic miso_n;

    assign tick = (q.tick_cnt == 5'(SCLK_HALF - 1));
    // Filtered level seen this cycle; a registered copy would be late
    assign miso_n = (q.miso_s[1] == q.miso_s[2]) ? q.miso_s[2] : q.miso_l;
    assign rx_byte = {q.rx_sh[6:0], miso_n};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Divider, bit sequencer and pin synchronisers
    always_comb begin
        d = q;
        d.rd_valid = 1'b0;
        d.done = 1'b0;
        d.miso_s = {q.miso_s[SYNC_N-2:0], link.miso_pin};
        d.irq_s = {q.irq_s[SYNC_N-2:0], link.irq};
        if (q.miso_s[1] == q.miso_s[2]) d.miso_l = q.miso_s[2];
        if (q.irq_s[1] == q.irq_s[2]) d.irq_l = q.irq_s[2];
        d.tick_cnt = tick ? 5'd0 : q.tick_cnt + 5'd1;
        unique case (q.st)
            TSP_IDLE: begin
                d.tick_cnt = 5'd0;
                if (req_valid) begin
                    d.cs_n = 1'b0;
                    d.wr = req_write;
                    d.left = req_len;
                    d.first = 1'b1;
                    d.bit_cnt = 3'd0;
                    d.tx_sh = {~req_write, req_addr};
                    d.st = TSP_HIGH;
                end
            end
            TSP_HIGH: begin
                if (tick) begin
                    d.sclk = 1'b0;
                    d.mosi = q.tx_sh[7];
                    d.tx_sh = {q.tx_sh[6:0], 1'b0};
                    d.st = TSP_LOW;
                end
            end
            TSP_LOW: begin
                if (tick) begin
                    d.sclk = 1'b1;
                    d.rx_sh = rx_byte;
                    d.bit_cnt = q.bit_cnt + 3'd1;
                    d.st = TSP_HIGH;
                    if (q.bit_cnt == 3'd7) begin
                        d.first = 1'b0;
                        if (!q.first && !q.wr) begin
                            d.rd_data = rx_byte;
                            d.rd_valid = 1'b1;
                        end
                        if (q.left == '0) begin
                            d.st = TSP_HOLD;
                        end else begin
                            d.left = q.left - LEN_W'(1);
                            d.tx_sh = 8'h00;
                            if (q.wr) d.st = TSP_FETCH;
                        end
                    end
                end
            end
            TSP_FETCH: begin
                // Clock stays high while the user has no byte ready
                d.tick_cnt = 5'd0;
                if (wr_valid) begin
                    d.tx_sh = wr_data;
                    d.st = TSP_HIGH;
                end
            end
            TSP_HOLD: begin
                if (tick) begin
                    d.cs_n = 1'b1;
                    d.done = 1'b1;
                    d.st = TSP_GAP;
                end
            end
            TSP_GAP: begin
                if (tick) d.st = TSP_IDLE;
            end
            default: begin
                d.st = TSP_IDLE;
                d.cs_n = 1'b1;
                d.sclk = CPOL;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.st <= TSP_IDLE;
            q.sclk <= CPOL;
            q.cs_n <= 1'b1;
            q.miso_s <= '1;
            q.miso_l <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign req_ready = (q.st == TSP_IDLE);
    assign wr_ready = (q.st == TSP_FETCH);
    assign link.sclk = q.sclk;
    assign link.cs_n = q.cs_n;
    assign link.mosi = q.mosi;
    assign rd_data = q.rd_data;
    assign rd_valid = q.rd_valid;
    assign done = q.done;
    assign meas_ready = q.irq_l;
endmodule : tsp_host

// file: tsp_sva.sv
// Checker for the link pins between the host and device ends.
// Assumes the host divides its clock to half periods of 8 clocks.
`timescale 1ns/1ps
module tsp_sva #(
    parameter int MEAS_CYCLES = 20
) (
    input logic clk,
    input logic rst,
    input logic sclk,
    input logic cs_n,
    input logic mosi,
    input logic miso,
    input logic miso_oe,
    input logic irq
);
    logic sclk_q;
    logic [7:0] rises_q;
    logic [15:0] idle_q;

    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    // Count rises per frame and clocks since the last deselect
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b1;
            rises_q <= 8'h00;
            idle_q <= 16'h0000;
        end else begin
            sclk_q <= sclk;
            if (cs_n) begin
                rises_q <= 8'h00;
            end else if (sclk && !sclk_q) begin
                rises_q <= rises_q + 8'h01;
            end
            if (!cs_n) begin
                idle_q <= 16'h0000;
            end else if (idle_q != 16'hffff) begin
                idle_q <= idle_q + 16'h0001; // Saturates on long idles
            end
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_low_phase;
        !sclk [*8] ##1 sclk;
    endsequence
    sequence s_oe_on;
        !miso_oe [*4] ##[1:2] miso_oe;
    endsequence

    property p_sclk_idle;
        cs_n |-> sclk;
    endproperty
    property p_mosi_edge;
        !cs_n && $changed(mosi) |-> !sclk;
    endproperty
    property p_miso_edge;
        miso_oe && !cs_n && $changed(miso) |-> !sclk;
    endproperty
    property p_frame_bytes;
        $rose(cs_n) |-> rises_q != 8'h00 && rises_q[2:0] == 3'h0;
    endproperty
    property p_half_low;
        $fell(sclk) |-> s_low_phase;
    endproperty
    property p_oe_on;
        $fell(cs_n) |-> s_oe_on;
    endproperty
    property p_oe_off;
        cs_n [*6] |-> !miso_oe;
    endproperty
    property p_irq_stand;
        irq && cs_n |=> irq;
    endproperty
    property p_irq_clear;
        $fell(cs_n) |-> ##[1:6] !irq;
    endproperty
    property p_meas_alone;
        $rose(irq) |-> idle_q >= MEAS_CYCLES;
    endproperty

    a_sclk_idle: assert property (p_sclk_idle)
        else $error("serial clock low while deselected");
    a_mosi_edge: assert property (p_mosi_edge)
        else $error("host data moved while clock high");
    a_miso_edge: assert property (p_miso_edge)
        else $error("device data moved while clock high");
    a_frame_bytes: assert property (p_frame_bytes)
        else $error("frame not a whole number of bytes");
    a_half_low: assert property (p_half_low)
        else $error("clock low phase not eight clocks");
    a_oe_on: assert property (p_oe_on)
        else $error("data output not enabled after select");
    a_oe_off: assert property (p_oe_off)
        else $error("data output driven while deselected");
    a_irq_stand: assert property (p_irq_stand)
        else $error("done line dropped without a select");
    a_irq_clear: assert property (p_irq_clear)
        else $error("done line kept after select");
    a_meas_alone: assert property (p_meas_alone)
        else $error("done line rose too soon after deselect");
endmodule : tsp_sva

// file: tsp_test.sv
// Bench joining the host and device ends over one link interface.
// Assumes package constants; measurement length cut short for speed.
`timescale 1ns/1ps
module tsp_test;
    import tsp_pkg::*;
    localparam int MEAS = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic wr_valid = 1'b0;
    logic [6:0] req_addr = 7'h00;
    logic [7:0] req_len = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] meas_result = 8'h00;
    logic req_ready, wr_ready, rd_valid, done, meas_ready, meas_busy;
    logic [7:0] rd_data, meas_config, frame_count, nfr, mosi_sh, miso_sh;
    logic [7:0] wbuf [0:16];
    logic [7:0] rbuf [0:15];
    logic [7:0] cfg [0:15];
    logic [31:0] seed = 32'h0000_5a7b;
    int nrd = 0;
    int n_mismatch = 0;
    int num_checks = 0;

    tsp_if link ();
    tsp_host tsp_host_inst (.clk(clk), .rst(rst), .link(link),
        .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_len(req_len),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
        .meas_ready(meas_ready));
    tsp_dev #(.MEAS_CYCLES(MEAS)) tsp_dev_inst (.clk(clk), .rst(rst),
        .link(link), .meas_result(meas_result), .meas_config(meas_config),
        .meas_busy(meas_busy), .frame_count(frame_count));
    tsp_sva #(.MEAS_CYCLES(MEAS)) tsp_sva_inst (.clk(clk), .rst(rst),
        .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
        .miso(link.miso), .miso_oe(link.miso_oe), .irq(link.irq));

    // 25 MHz clock
    always #20 clk = ~clk;

    // Shift both data lines on the rising clock edge, as a sampler would
    always @(posedge link.sclk) begin
        if (!link.cs_n) begin
            mosi_sh <= {mosi_sh[6:0], link.mosi};
            miso_sh <= {miso_sh[6:0], link.miso_pin};
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic void nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
    endfunction : nxt

    // Config bytes read back as written; other plain addresses read zero
    function automatic logic [7:0] exp_rd(input int x);
        return (x < 16) ? cfg[x] : 8'h00;
    endfunction : exp_rd

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // One framed transfer; bytes are fed on demand, held until taken
    task automatic run(input logic w, input logic [6:0] a, input int n);
        int k;
        k = 0;
        nrd = 0;
        req_write <= w;
        req_addr <= a;
        req_len <= 8'(n);
        req_valid <= 1'b1;
        wr_valid <= w;
        wr_data <= wbuf[0];
        for (int t = 0; t <= 5000; t++) begin
            if (t == 5000) begin
                n_mismatch++;
                wrap_up();
            end
            @(posedge clk);
            if (req_valid && req_ready) req_valid <= 1'b0;
            if (wr_valid && wr_ready) begin
                k++;
                wr_data <= wbuf[k];
                if (k == n) wr_valid <= 1'b0;
            end
            if (rd_valid) begin
                rbuf[nrd] = rd_data;
                nrd++;
            end
            if (done) break;
        end
    endtask : run

    // Write random bytes, then read them back over the same range
    task automatic wr_chk(input logic [6:0] a, input int n);
        for (int i = 0; i < n; i++) begin
            nxt();
            wbuf[i] = seed[7:0];
            if (a + i < 16) cfg[a + i] = seed[7:0];
        end
        run(1'b1, a, n);
        chk(mosi_sh, wbuf[n - 1]);
        run(1'b0, a, n);
        chk(8'(nrd), 8'(n));
        chk(miso_sh, exp_rd(a + n - 1));
        for (int i = 0; i < n; i++) chk(rbuf[i], exp_rd(a + i));
    endtask : wr_chk

    // Start a measurement; optionally select the device while it runs
    task automatic measure(input logic abort);
        int t;
        nxt();
        meas_result <= seed[7:0];
        wbuf[0] = seed[15:8];
        run(1'b1, ADDR_START, 1);
        // Busy shows once the start frame has closed
        repeat (4) @(posedge clk);
        chk({7'h00, meas_busy}, 8'h01);
        if (abort) begin
            run(1'b0, ADDR_FRAMES, 1);
            chk(rbuf[0], nfr);
            chk({7'h00, meas_busy}, 8'h00);
        end
        t = 0;
        while (meas_ready !== 1'b1 && t < 300) begin
            @(posedge clk);
            t++;
        end
        if (!abort) nfr++;
        chk({6'h00, meas_ready, link.irq}, abort ? 8'h00 : 8'h03);
        if (!abort && t == 300) wrap_up();
        chk(frame_count, nfr);
        if (!abort) begin
            // Status is read after the select has cleared the done flag
            run(1'b0, ADDR_STATUS, 3);
            chk(rbuf[0], 8'h00);
            chk(rbuf[1], meas_result);
            chk(rbuf[2], nfr);
            chk({7'h00, link.irq}, 8'h00);
        end
        $display("test measure abort=%0d done", abort);
    endtask : measure

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        nfr = 8'h00;
        for (int i = 0; i < 16; i++) cfg[i] = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (100) @(posedge clk);
        // Idle link and no measurement without a start
        chk({5'h00, link.sclk, link.cs_n, link.miso_pin}, 8'h07);
        chk({7'h00, link.irq}, 8'h00);
        chk(frame_count, 8'h00);
        $display("test idle done");
        wr_chk(7'h00, 16);
        for (int i = 0; i < 6; i++) begin
            int n;
            nxt();
            n = 1 + int'(seed[1:0]);
            wr_chk(7'(int'(seed[7:4]) % (17 - n)), n);
        end
        wr_chk(7'h0e, 2);
        wr_chk(7'h20, 2);
        chk(meas_config, cfg[0]);
        $display("test registers done");
        measure(1'b0);
        measure(1'b1);
        wr_chk(7'h00, 1);
        measure(1'b0);
        wrap_up();
    end
endmodule : tsp_test
